// ---- host_irq_model.sv ----
// Purpose: host side that collects the routed management interrupts.
// Assumes: routes are levels synchronous to sys_clk_in.
// Notes: sticky, so a short assertion is never missed by the bench.
`timescale 1ns/1ns
`default_nettype none
module host_irq_model
(
   // clock and reset
   input wire sys_clk_in,
   input wire rst_b_in,
   // routed interrupts
   input wire mgmt_irq_pin_b_out,
   input wire serial_irq_req_out,
   input wire wake_event_out,
   // seen flags: pin, serial, wake
   output logic [2:0] host_seen_out
);
   // pin is active low, the others high
   always @(posedge sys_clk_in)
      if (!rst_b_in)
         host_seen_out <= 3'b000;
      else
         host_seen_out <= host_seen_out | {!mgmt_irq_pin_b_out, serial_irq_req_out,
            wake_event_out};
endmodule // host_irq_model
`default_nettype wire

// ---- mgmt_interrupt_aggregator.v ----
// Purpose: management interrupt status, enables and routing, with an
//          AXI4-Lite register port.
// Assumes: all inputs synchronous to sys_clk_in; event inputs are one-cycle
//          pulses, peripheral interrupt inputs are levels.
// Notes:   every output comes straight from a flop, so the group interrupt
//          and its routes lag the status by one cycle.
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
`include "mgmt_irq_defines.vh"
module mgmt_interrupt_aggregator
(
   // clock and reset
   input wire sys_clk_in,
   input wire rst_b_in,
   // axi4-lite write address
   input wire s_axi_awvalid_in,
   output wire s_axi_awready_out,
   input wire [7:0] s_axi_awaddr_in,
   input wire [2:0] s_axi_awprot_in,
   // axi4-lite write data
   input wire s_axi_wvalid_in,
   output wire s_axi_wready_out,
   input wire [31:0] s_axi_wdata_in,
   input wire [3:0] s_axi_wstrb_in,
   // axi4-lite write response
   output wire s_axi_bvalid_out,
   input wire s_axi_bready_in,
   output wire [1:0] s_axi_bresp_out,
   // axi4-lite read address
   input wire s_axi_arvalid_in,
   output wire s_axi_arready_out,
   input wire [7:0] s_axi_araddr_in,
   input wire [2:0] s_axi_arprot_in,
   // axi4-lite read data
   output wire s_axi_rvalid_out,
   input wire s_axi_rready_in,
   output wire [31:0] s_axi_rdata_out,
   output wire [1:0] s_axi_rresp_out,
   // pin events, one-cycle pulses
   input wire [7:0] pin_event_a_in,
   input wire [7:0] pin_event_b_in,
   input wire [3:0] pin_event_54_57_in,
   input wire fan_speed_event_1_in,
   input wire fan_speed_event_2_in,
   // peripheral interrupt levels
   input wire parallel_irq_in,
   input wire serial2_irq_in,
   input wire serial1_irq_in,
   input wire floppy_irq_in,
   input wire midi_irq_in,
   input wire mouse_irq_in,
   input wire keyboard_irq_in,
   input wire port92_event_in,
   input wire infrared_rx_in,
   // group interrupt and its routes
   output wire group_mgmt_irq_out,
   output wire mgmt_irq_pin_b_out,
   output wire serial_irq_req_out,
   output wire wake_event_out
);
   // ----
   // declarations
   // ----
   reg awready_q;
   reg wready_q;
   reg bvalid_q;
   reg [1:0] bresp_q;
   reg arready_q;
   reg rvalid_q;
   reg [31:0] rdata_q;
   reg [1:0] rresp_q;
   reg [5:0] wr_idx_q;
   reg [7:0] wr_byte_q;
   reg wr_lane_q;
   reg [7:0] en_periph_q;
   reg [7:0] en_routing_q;
   reg [7:0] en_pins_a_q;
   reg [7:0] en_pins_b_q;
   reg [7:0] en_pins_fans_q;
   reg [7:0] periph_q;
   reg [1:0] inputs_lvl_q;
   reg infrared_q;
   reg port92_q;
   reg group_q;
   reg pin_b_q;
   reg serial_q;
   reg wake_q;
   reg [7:0] rd_byte_d;
   reg rd_hit_d;
   reg wr_hit_d;
   wire aw_take;
   wire w_take;
   wire wr_fire;
   wire ar_take;
   wire [5:0] wr_idx_now;
   wire [5:0] rd_idx;
   wire [7:0] wr_one;
   wire [7:0] clr_a;
   wire [7:0] clr_b;
   wire [7:0] clr_fans;
   wire [7:0] set_fans;
   wire [7:0] status_a;
   wire [7:0] status_b;
   wire [7:0] status_fans;
   wire [7:0] status_inputs;
   wire infrared_edge;
   wire infrared_rd_clr;
   wire port92_clr;
   wire group_d;

   // -----------------------------------------------------------------------
   // write channel: address and data taken in either order
   // -----------------------------------------------------------------------
   // a ready that is high means nothing of that kind is held
   assign aw_take = s_axi_awvalid_in & awready_q;
   assign w_take = s_axi_wvalid_in & wready_q;
   // write happens once both halves are in and no response is pending
   assign wr_fire = ~awready_q & ~wready_q & ~bvalid_q;
   assign wr_idx_now = wr_idx_q;
   assign wr_one = (wr_fire & wr_lane_q) ? wr_byte_q : 8'h00;

   // hold address and data until the write fires
   always @(posedge sys_clk_in)
   begin
      if (!rst_b_in)
      begin
         awready_q <= 1'b1;
         wready_q <= 1'b1;
         wr_idx_q <= 6'h00;
         wr_byte_q <= 8'h00;
         wr_lane_q <= 1'b0;
      end
      else
      begin
         if (aw_take)
         begin
            awready_q <= 1'b0;
            wr_idx_q <= s_axi_awaddr_in[7:2];
         end
         else if (wr_fire)
            awready_q <= 1'b1;
         if (w_take)
         begin
            wready_q <= 1'b0;
            wr_byte_q <= s_axi_wdata_in[7:0];
            wr_lane_q <= s_axi_wstrb_in[0]; // only the low lane carries data
         end
         else if (wr_fire)
            wready_q <= 1'b1;
      end
   end

   // write decode: unmapped indices answer with a slave error
   always @*
   begin
      if (wr_idx_now >= `IDX_STATUS_PERIPH && wr_idx_now <= `IDX_ENABLE_PINS_FANS)
         wr_hit_d = 1'b1;
      else
         wr_hit_d = 1'b0;
   end

   // write response
   always @(posedge sys_clk_in)
   begin
      if (!rst_b_in)
      begin
         bvalid_q <= 1'b0;
         bresp_q <= `RESP_OKAY;
      end
      else if (wr_fire)
      begin
         bvalid_q <= 1'b1;
         bresp_q <= wr_hit_d ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_bready_in)
         bvalid_q <= 1'b0;
   end

   // ----
   // enable registers
   // ----
   // reserved bits are never stored, so they read back as zero
   always @(posedge sys_clk_in)
   begin
      if (!rst_b_in)
      begin
         en_periph_q <= `RESET_BYTE; // RULE17
         en_routing_q <= `RESET_BYTE;
         en_pins_a_q <= `RESET_BYTE;
         en_pins_b_q <= `RESET_BYTE;
         en_pins_fans_q <= `RESET_BYTE;
      end
      else if (wr_fire && wr_lane_q)
      begin
         if (wr_idx_now == `IDX_ENABLE_PERIPH)
            en_periph_q <= wr_byte_q & `MASK_PERIPH; // RULE6
         else if (wr_idx_now == `IDX_ENABLE_ROUTING)
            en_routing_q <= wr_byte_q & `MASK_ROUTING; // RULE7
         else if (wr_idx_now == `IDX_ENABLE_PINS_A)
            en_pins_a_q <= wr_byte_q & `MASK_PINS_A; // RULE11
         else if (wr_idx_now == `IDX_ENABLE_PINS_B)
            en_pins_b_q <= wr_byte_q & `MASK_PINS_B; // RULE12
         else if (wr_idx_now == `IDX_ENABLE_PINS_FANS)
            en_pins_fans_q <= wr_byte_q & `MASK_PINS_FANS;
      end
   end

   // -----------------------------------------------------------------------
   // sticky pin status, cleared by writing one
   // -----------------------------------------------------------------------
   assign clr_a = (wr_idx_now == `IDX_STATUS_PINS_A) ? wr_one : 8'h00; // RULE1
   assign clr_b = (wr_idx_now == `IDX_STATUS_PINS_B) ? wr_one : 8'h00;
   assign clr_fans = (wr_idx_now == `IDX_STATUS_PINS_FANS) ? wr_one : 8'h00;
   // tach events land in the top two bits, bits 4 and 5 stay reserved
   assign set_fans = {fan_speed_event_2_in, fan_speed_event_1_in, 2'b00,
                      pin_event_54_57_in}; // RULE4

   // pins 20-22, reserved, 24-26, 60
   sticky_status8 #(.IMPL_MASK(`MASK_PINS_A)) u_status_a
   (
      .sys_clk_in(sys_clk_in),
      .rst_b_in(rst_b_in),
      .set_in(pin_event_a_in), // RULE2
      .clr_in(clr_a),
      .status_out(status_a)
   );

   // pins 30-33, 41-43, 61
   sticky_status8 #(.IMPL_MASK(`MASK_PINS_B)) u_status_b
   (
      .sys_clk_in(sys_clk_in),
      .rst_b_in(rst_b_in),
      .set_in(pin_event_b_in), // RULE3
      .clr_in(clr_b),
      .status_out(status_b)
   );

   // pins 54-57 and both fan tachometers
   sticky_status8 #(.IMPL_MASK(`MASK_PINS_FANS)) u_status_fans
   (
      .sys_clk_in(sys_clk_in),
      .rst_b_in(rst_b_in),
      .set_in(set_fans),
      .clr_in(clr_fans),
      .status_out(status_fans)
   );

   // -----------------------------------------------------------------------
   // peripheral and input status
   // -----------------------------------------------------------------------
   // infrared receive line: either edge counts
   transition_detect u_infrared_edge
   (
      .sys_clk_in(sys_clk_in),
      .rst_b_in(rst_b_in),
      .level_in(infrared_rx_in),
      .pulse_out(infrared_edge)
   );

   // a read of the input status register clears infrared
   assign infrared_rd_clr = ar_take && (rd_idx == `IDX_STATUS_INPUTS);
   assign port92_clr = wr_idx_now == `IDX_STATUS_INPUTS && wr_one[`BIT_INPUTS_PORT92];

   // level bits track their sources; writes cannot touch them
   always @(posedge sys_clk_in)
   begin
      if (!rst_b_in)
      begin
         periph_q <= `RESET_BYTE;
         inputs_lvl_q <= 2'b00;
         infrared_q <= 1'b0;
         port92_q <= 1'b0;
      end
      else
      begin
         periph_q <= {2'b00, midi_irq_in, floppy_irq_in, serial1_irq_in,
                      serial2_irq_in, parallel_irq_in, 1'b0}; // RULE14
         inputs_lvl_q <= {keyboard_irq_in, mouse_irq_in};
         // a new edge beats the read that clears it
         if (infrared_edge)
            infrared_q <= 1'b1; // RULE15
         else if (infrared_rd_clr)
            infrared_q <= 1'b0;
         if (port92_event_in)
            port92_q <= 1'b1;
         else if (port92_clr)
            port92_q <= 1'b0;
      end
   end

   assign status_inputs = {3'b000, port92_q, 1'b0, infrared_q, inputs_lvl_q};

   // -----------------------------------------------------------------------
   // group interrupt and routing
   // -----------------------------------------------------------------------
   // any set status bit whose enable is one asserts the group
   assign group_d = |(periph_q & en_periph_q) // RULE13
                  | |(status_inputs & en_routing_q & `MASK_INPUTS) // RULE7
                  | |(status_a & en_pins_a_q) // RULE11
                  | |(status_b & en_pins_b_q) // RULE12
                  | |(status_fans & en_pins_fans_q); // RULE16

   // routes are registered from the same combined term, so they line up
   always @(posedge sys_clk_in)
   begin
      if (!rst_b_in)
      begin
         group_q <= 1'b0;
         pin_b_q <= 1'b1;
         serial_q <= 1'b0;
         wake_q <= 1'b0;
      end
      else
      begin
         group_q <= group_d; // RULE16
         pin_b_q <= ~(group_d & en_routing_q[`BIT_GROUP_TO_PIN]); // RULE10
         serial_q <= group_d & en_routing_q[`BIT_GROUP_TO_SERIAL]; // RULE9
         wake_q <= group_d & en_routing_q[`BIT_GROUP_TO_WAKE]; // RULE8
      end
   end

   // -----------------------------------------------------------------------
   // read channel
   // -----------------------------------------------------------------------
   // one read at a time; data registered at the address handshake
   assign ar_take = s_axi_arvalid_in & arready_q;
   assign rd_idx = s_axi_araddr_in[7:2];

   // read mux; the slot after the fan status always reads zero
   always @*
   begin
      rd_hit_d = 1'b1;
      if (rd_idx == `IDX_STATUS_PERIPH)
         rd_byte_d = periph_q;
      else if (rd_idx == `IDX_STATUS_INPUTS)
         rd_byte_d = status_inputs;
      else if (rd_idx == `IDX_STATUS_PINS_A)
         rd_byte_d = status_a;
      else if (rd_idx == `IDX_STATUS_PINS_B)
         rd_byte_d = status_b;
      else if (rd_idx == `IDX_STATUS_PINS_FANS)
         rd_byte_d = status_fans;
      else if (rd_idx == `IDX_RESERVED_ZERO)
         rd_byte_d = 8'h00; // RULE5
      else if (rd_idx == `IDX_ENABLE_PERIPH)
         rd_byte_d = en_periph_q;
      else if (rd_idx == `IDX_ENABLE_ROUTING)
         rd_byte_d = en_routing_q;
      else if (rd_idx == `IDX_ENABLE_PINS_A)
         rd_byte_d = en_pins_a_q;
      else if (rd_idx == `IDX_ENABLE_PINS_B)
         rd_byte_d = en_pins_b_q;
      else if (rd_idx == `IDX_ENABLE_PINS_FANS)
         rd_byte_d = en_pins_fans_q;
      else
      begin
         rd_byte_d = 8'h00;
         rd_hit_d = 1'b0;
      end
   end

   // read handshake and data hold
   always @(posedge sys_clk_in)
   begin
      if (!rst_b_in)
      begin
         arready_q <= 1'b1;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h00000000;
         rresp_q <= `RESP_OKAY;
      end
      else if (ar_take)
      begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b1;
         rdata_q <= {24'h000000, rd_byte_d};
         rresp_q <= rd_hit_d ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (rvalid_q && s_axi_rready_in)
      begin
         rvalid_q <= 1'b0;
         arready_q <= 1'b1;
      end
   end

   // ----
   // outputs, all from flops
   // ----
   assign s_axi_awready_out = awready_q;
   assign s_axi_wready_out = wready_q;
   assign s_axi_bvalid_out = bvalid_q;
   assign s_axi_bresp_out = bresp_q;
   assign s_axi_arready_out = arready_q;
   assign s_axi_rvalid_out = rvalid_q;
   assign s_axi_rdata_out = rdata_q;
   assign s_axi_rresp_out = rresp_q;
   assign group_mgmt_irq_out = group_q;
   assign mgmt_irq_pin_b_out = pin_b_q;
   assign serial_irq_req_out = serial_q;
   assign wake_event_out = wake_q;
endmodule // mgmt_interrupt_aggregator
`default_nettype wire

// ---- mgmt_interrupt_aggregator_tb.sv ----
// Purpose: register and interrupt tests for the management aggregator.
// Assumes: bready and rready held high, so answers are taken at once.
// Notes: byte address is four times the register index.
`timescale 1ns/1ns
`default_nettype none
`include "mgmt_irq_defines.vh"
module mgmt_interrupt_aggregator_tb;
   logic sys_clk_in = 1'b0, rst_b_in = 1'b0, s_axi_bready_in = 1'b1, s_axi_rready_in = 1'b1;
   logic s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_arvalid_in = 1'b0;
   logic [7:0] s_axi_awaddr_in = 8'h00, s_axi_araddr_in = 8'h00;
   logic [2:0] s_axi_awprot_in = 3'h0, s_axi_arprot_in = 3'h0;
   logic [31:0] s_axi_wdata_in = 32'h0;
   logic [3:0] s_axi_wstrb_in = 4'h1, pin_event_54_57_in = 4'h0;
   logic [7:0] pin_event_a_in = 8'h00, pin_event_b_in = 8'h00;
   logic fan_speed_event_1_in = 1'b0, fan_speed_event_2_in = 1'b0, port92_event_in = 1'b0;
   logic parallel_irq_in = 1'b0, serial2_irq_in = 1'b0, serial1_irq_in = 1'b0;
   logic floppy_irq_in = 1'b0, midi_irq_in = 1'b0, mouse_irq_in = 1'b0;
   logic keyboard_irq_in = 1'b0, infrared_rx_in = 1'b0;
   wire s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
   wire s_axi_rvalid_out, group_mgmt_irq_out, mgmt_irq_pin_b_out;
   wire serial_irq_req_out, wake_event_out;
   wire [1:0] s_axi_bresp_out, s_axi_rresp_out;
   wire [31:0] s_axi_rdata_out;
   logic [2:0] host_seen_out;
   logic [31:0] rd;
   logic [1:0] resp;
   logic [6:0] lvl;
   int bad_count = 0, num_checks = 0;
   mgmt_interrupt_aggregator dut (.*);
   host_irq_model host (.*);
   // 20 mhz clock
   always #25 sys_clk_in = ~sys_clk_in;
   // ----
   // bus and compare tasks
   // ----
   function automatic logic [7:0] ba(input int i);
      return {i[5:0], 2'b00};
   endfunction
   task automatic cyc(input int k);
      repeat (k) @(posedge sys_clk_in);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [7:0] d);
      s_axi_awaddr_in <= a;
      s_axi_wdata_in <= {24'h0, d};
      s_axi_awvalid_in <= 1'b1;
      s_axi_wvalid_in <= 1'b1;
      do
      begin
         @(posedge sys_clk_in);
         if (s_axi_awready_out && s_axi_awvalid_in) s_axi_awvalid_in <= 1'b0;
         if (s_axi_wready_out && s_axi_wvalid_in) s_axi_wvalid_in <= 1'b0;
      end
      while (s_axi_bvalid_out !== 1'b1);
      resp = s_axi_bresp_out;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      s_axi_araddr_in <= a;
      s_axi_arvalid_in <= 1'b1;
      do
      begin
         @(posedge sys_clk_in);
         if (s_axi_arready_out && s_axi_arvalid_in) s_axi_arvalid_in <= 1'b0;
      end
      while (s_axi_rvalid_out !== 1'b1);
      chk(s_axi_rdata_out, e);
      chk({30'h0, s_axi_rresp_out}, {30'h0, er});
   endtask
   // one-cycle event pulses; f is port92, fan 2, fan 1, pins 57..54
   task automatic pulse(input logic [7:0] a, input logic [7:0] b, input logic [6:0] f);
      pin_event_a_in <= a;
      pin_event_b_in <= b;
      {port92_event_in, fan_speed_event_2_in, fan_speed_event_1_in, pin_event_54_57_in} <= f;
      cyc(1);
      pin_event_a_in <= 8'h00;
      pin_event_b_in <= 8'h00;
      {port92_event_in, fan_speed_event_2_in, fan_speed_event_1_in, pin_event_54_57_in} <= 7'h0;
      cyc(3);
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // watchdog, far beyond the few hundred cycles the tests need
   initial
   begin
      cyc(20000);
      bad_count++;
      end_of_test();
   end
   // ----
   // test sequence
   // ----
   initial
   begin
      cyc(4);
      rst_b_in <= 1'b1;
      cyc(1);
      for (int i = 6'h12; i <= 6'h19; i++) rd_chk(ba(i), 32'h0, 2'b00);
      for (int i = 0; i < 4; i++)
      begin
         axi_wr(ba(6'h16 + i), 8'hff);
         rd_chk(ba(6'h16 + i), (i == 0) ? 32'h3e : (i == 3) ? 32'hff : 32'hf7, 2'b00);
         axi_wr(ba(6'h16 + i), 8'h00);
      end
      axi_wr(ba(`IDX_RESERVED_ZERO), 8'hff);
      rd_chk(ba(`IDX_RESERVED_ZERO), 32'h0, 2'b00);
      axi_wr(8'hfc, 8'h01);
      chk({30'h0, resp}, 32'h2);
      rd_chk(8'hfc, 32'h0, 2'b10);
      // latch every pin and fan event, not port92, with all enables off
      pulse(8'hff, 8'hff, 7'h3f);
      chk({31'h0, group_mgmt_irq_out}, 32'h0);
      rd_chk(ba(6'h12), 32'hf7, 2'b00);
      rd_chk(ba(6'h13), 32'hff, 2'b00);
      rd_chk(ba(6'h14), 32'hcf, 2'b00);
      axi_wr(ba(6'h12), 8'h01);
      rd_chk(ba(6'h12), 32'hf6, 2'b00);
      for (int i = 6'h12; i <= 6'h14; i++)
      begin
         axi_wr(ba(i), 8'hff);
         rd_chk(ba(i), 32'h0, 2'b00);
      end
      // gating and routing; pin b event blocked until enabled
      axi_wr(ba(6'h17), 8'he0);
      axi_wr(ba(6'h18), 8'h80);
      pulse(8'h00, 8'h01, 7'h0);
      chk({31'h0, group_mgmt_irq_out}, 32'h0);
      pulse(8'h80, 8'h00, 7'h0);
      chk({31'h0, group_mgmt_irq_out}, 32'h1);
      chk({29'h0, host_seen_out}, 32'h7);
      axi_wr(ba(6'h17), 8'h00);
      cyc(2);
      chk({29'h0, mgmt_irq_pin_b_out, serial_irq_req_out, wake_event_out}, 32'h4);
      axi_wr(ba(6'h12), 8'h80);
      cyc(2);
      chk({31'h0, group_mgmt_irq_out}, 32'h0);
      axi_wr(ba(6'h19), 8'h01);
      cyc(2);
      chk({31'h0, group_mgmt_irq_out}, 32'h1);
      axi_wr(ba(6'h13), 8'hff);
      // level sources cannot be cleared by software
      axi_wr(ba(6'h16), 8'h3e);
      axi_wr(ba(6'h17), 8'h03);
      for (int i = 0; i < 7; i++)
      begin
         lvl = 7'h1 << i;
         {keyboard_irq_in, mouse_irq_in, midi_irq_in, floppy_irq_in, serial1_irq_in,
            serial2_irq_in, parallel_irq_in} <= lvl;
         cyc(3);
         axi_wr(ba(6'h10), 8'hff);
         axi_wr(ba(6'h11), 8'hff);
         chk({31'h0, group_mgmt_irq_out}, 32'h1);
         rd_chk(ba(6'h10), {26'h0, lvl[4:0], 1'b0}, 2'b00);
         rd_chk(ba(6'h11), {30'h0, lvl[6:5]}, 2'b00);
      end
      {keyboard_irq_in, mouse_irq_in, midi_irq_in, floppy_irq_in, serial1_irq_in,
         serial2_irq_in, parallel_irq_in} <= 7'h0;
      axi_wr(ba(6'h17), 8'h14);
      cyc(3);
      chk({31'h0, group_mgmt_irq_out}, 32'h0);
      pulse(8'h00, 8'h00, 7'h40);
      rd_chk(ba(6'h11), 32'h10, 2'b00);
      axi_wr(ba(6'h11), 8'h10);
      rd_chk(ba(6'h11), 32'h0, 2'b00);
      // infrared: a rising edge sets, a read clears
      infrared_rx_in <= 1'b1;
      cyc(3);
      chk({31'h0, group_mgmt_irq_out}, 32'h1);
      rd_chk(ba(6'h11), 32'h04, 2'b00);
      rd_chk(ba(6'h11), 32'h0, 2'b00);
      cyc(2);
      chk({31'h0, group_mgmt_irq_out}, 32'h0);
      end_of_test();
   end
endmodule // mgmt_interrupt_aggregator_tb
`default_nettype wire

// ---- mgmt_irq_checker.sv ----
// Purpose: port assertions for the management interrupt aggregator.
// Assumes: one clock, synchronous active-low reset.
// Notes: routing enables are internal, so each route is tied to the group.
`timescale 1ns/1ns
`default_nettype none
module mgmt_irq_checker
(
   // clock and reset
   input wire sys_clk_in,
   input wire rst_b_in,
   // register bus
   input wire s_axi_awvalid_in,
   input wire s_axi_awready_out,
   input wire s_axi_wvalid_in,
   input wire s_axi_wready_out,
   input wire s_axi_bvalid_out,
   input wire s_axi_arvalid_in,
   input wire s_axi_arready_out,
   input wire [7:0] s_axi_araddr_in,
   input wire s_axi_rvalid_out,
   input wire [31:0] s_axi_rdata_out,
   input wire [1:0] s_axi_rresp_out,
   // interrupt outputs
   input wire group_mgmt_irq_out,
   input wire mgmt_irq_pin_b_out,
   input wire serial_irq_req_out,
   input wire wake_event_out
);
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rst_b_in);
   // ----
   // bus steps
   // ----
   sequence s_wr_taken;
      s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
   endsequence
   sequence s_rd_taken;
      s_axi_arvalid_in && s_axi_arready_out;
   endsequence
   AST_WR_ANSWER: assert property (s_wr_taken |-> ##2 s_axi_bvalid_out)
      else $error("write answer missing");
   AST_RD_ANSWER: assert property (s_rd_taken |=> s_axi_rvalid_out)
      else $error("read answer missing");
   AST_RSV_SLOT: assert property (s_rd_taken ##0 (s_axi_araddr_in == 8'h54)
      |=> s_axi_rdata_out == 32'h0 && s_axi_rresp_out == 2'b00)
      else $error("reserved slot not zero");
   AST_PINS_A_RSV: assert property (s_rd_taken ##0 (s_axi_araddr_in == 8'h48)
      |=> !s_axi_rdata_out[3])
      else $error("pins a bit 3 set");
   AST_FANS_RSV: assert property (s_rd_taken ##0 (s_axi_araddr_in == 8'h50)
      |=> s_axi_rdata_out[5:4] == 2'b00)
      else $error("fans bits 5:4 set");
   AST_EN1_RSV: assert property (s_rd_taken ##0 (s_axi_araddr_in == 8'h58)
      |=> s_axi_rdata_out[7:6] == 2'b00 && !s_axi_rdata_out[0])
      else $error("enable reserved bits set");
   // a route may only carry a live group interrupt
   AST_WAKE_ROUTE: assert property (wake_event_out |-> group_mgmt_irq_out)
      else $error("wake without group");
   AST_SERIAL_ROUTE: assert property (serial_irq_req_out |-> group_mgmt_irq_out)
      else $error("serial request without group");
   AST_PIN_ROUTE: assert property (!mgmt_irq_pin_b_out |-> group_mgmt_irq_out)
      else $error("pin low without group");
   AST_RESET_IDLE: assert property ($rose(rst_b_in) |-> !group_mgmt_irq_out
      && mgmt_irq_pin_b_out && !serial_irq_req_out && !wake_event_out)
      else $error("outputs not idle after reset");
endmodule // mgmt_irq_checker

bind mgmt_interrupt_aggregator mgmt_irq_checker u_chk (.*);
`default_nettype wire

// ---- mgmt_irq_defines.vh ----
// Purpose: register indices, field positions and reset values for the
//          management interrupt aggregator.
// Assumes: one 32-bit AXI4-Lite word per register, byte address = 4 * index.
// Notes:   printed offsets are not word multiples, so they are kept as indices.
//
// Operation
// RULE1: writing one clears a status bit
// RULE2: status a latches pins 20-22, 24-26, 60
// RULE3: status b latches pins 30-33, 41-43, 61
// RULE4: status fans latches pins 54-57, tach 1-2
// RULE5: slot after status fans reads zero
// RULE6: enable peripherals gates parallel, serial, floppy, midi
// RULE7: enable routing gates mouse, keyboard, infrared, port92
// RULE8: routing bit 5 forwards group to wake
// RULE9: routing bit 6 forwards group to serial irq
// RULE10: routing bit 7 drives group onto pin
// RULE11: enable pins a gates status a bitwise
// RULE12: enable pins b gates status b bitwise
// RULE13: enable one admits source, zero blocks
// RULE14: peripheral status follows source, not clearable
// RULE15: infrared status sets on transition, read clears
// RULE16: group active when any enabled status set
// RULE17: all status and enables reset to zero
`ifndef MGMT_IRQ_DEFINES_VH
`define MGMT_IRQ_DEFINES_VH

// ----
// register indices (byte address is four times the index)
// ----
`define IDX_STATUS_PERIPH 6'h10
`define IDX_STATUS_INPUTS 6'h11
`define IDX_STATUS_PINS_A 6'h12
`define IDX_STATUS_PINS_B 6'h13
`define IDX_STATUS_PINS_FANS 6'h14
`define IDX_RESERVED_ZERO 6'h15
`define IDX_ENABLE_PERIPH 6'h16
`define IDX_ENABLE_ROUTING 6'h17
`define IDX_ENABLE_PINS_A 6'h18
`define IDX_ENABLE_PINS_B 6'h19
`define IDX_ENABLE_PINS_FANS 6'h1a

// ----
// implemented-bit masks; reserved bits read zero
// ----
`define MASK_PERIPH 8'h3e
`define MASK_INPUTS 8'h17
`define MASK_PINS_A 8'hf7
`define MASK_PINS_B 8'hff
`define MASK_PINS_FANS 8'hcf
`define MASK_ROUTING 8'hf7

// ----
// field positions
// ----
`define BIT_INPUTS_MOUSE 0
`define BIT_INPUTS_KEYBOARD 1
`define BIT_INPUTS_INFRARED 2
`define BIT_INPUTS_PORT92 4
`define BIT_GROUP_TO_WAKE 5
`define BIT_GROUP_TO_SERIAL 6
`define BIT_GROUP_TO_PIN 7

// ----
// reset values and bus answers
// ----
`define RESET_BYTE 8'h00
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ---- sticky_status8.v ----
// Purpose: eight sticky status bits, set by event, cleared by write-one.
// Assumes: set and clear strobes are one cycle wide.
// Notes:   a set in the cycle of its clear wins, so no event is lost.
`timescale 1ns/1ns
`default_nettype none
module sticky_status8
#(
   parameter [7:0] IMPL_MASK = 8'hff
)
(
   // clock and reset
   input wire sys_clk_in,
   input wire rst_b_in,
   // strobes
   input wire [7:0] set_in,
   input wire [7:0] clr_in,
   // state
   output wire [7:0] status_out
);
   reg [7:0] status_q;
   genvar i;

   // ----
   // one flop per bit; reserved bits stay at zero
   // ----
   generate
      for (i = 0; i < 8; i = i + 1)
      begin : g_bit
         if (IMPL_MASK[i])
         begin : g_impl
            always @(posedge sys_clk_in)
            begin
               if (!rst_b_in)
                  status_q[i] <= 1'b0; // RULE17
               else if (set_in[i])
                  status_q[i] <= 1'b1;
               else if (clr_in[i])
                  status_q[i] <= 1'b0; // RULE1
            end
         end
         else
         begin : g_rsvd
            always @(posedge sys_clk_in)
            begin
               status_q[i] <= 1'b0;
            end
         end
      end
   endgenerate

   assign status_out = status_q;
endmodule // sticky_status8
`default_nettype wire

// ---- transition_detect.v ----
// Purpose: one-cycle pulse on either edge of a synchronous level.
// Assumes: input already synchronous to sys_clk_in.
// Notes:   the first cycle after reset never pulses, whatever the level.
`timescale 1ns/1ns
`default_nettype none
module transition_detect
(
   // clock and reset
   input wire sys_clk_in,
   input wire rst_b_in,
   // level in, pulse out
   input wire level_in,
   output wire pulse_out
);
   reg last_q;
   reg primed_q;

   // ----
   // remember last level; primed suppresses a false edge out of reset
   // ----
   always @(posedge sys_clk_in)
   begin
      if (!rst_b_in)
      begin
         last_q <= 1'b0;
         primed_q <= 1'b0;
      end
      else
      begin
         last_q <= level_in;
         primed_q <= 1'b1;
      end
   end

   assign pulse_out = primed_q & (last_q ^ level_in);
endmodule // transition_detect
`default_nettype wire
